/* File: logic/ebac_defines.svh */
`ifndef EBAC_DEFINES_SVH
`define EBAC_DEFINES_SVH

// Register map
`define EBAC_AUX_CTRL_ADDR     8'h8E
`define EBAC_STATUS_ADDR       8'h8F

// Field positions in auxiliary_control
`define EBAC_SUPPRESS_BIT      0
`define EBAC_EXTDATA_BIT       1
`define EBAC_XRS_LSB           2
`define EBAC_XRS_MSB           4
`define EBAC_STRETCH_BIT       5

// Reset values
`define EBAC_XRS_RESET         3'h2
`define EBAC_BYTE_ZERO         8'h00

// Strobe timing in oscillator cycles
`define EBAC_STROBE_DIV_STD    4'h6
`define EBAC_STROBE_DIV_X2     4'h3
`define EBAC_MOVE_LEN_SHORT    5'h06
`define EBAC_MOVE_LEN_LONG     5'h1E

// Expanded RAM sizes in bytes
`define EBAC_XRAM_256          11'h100
`define EBAC_XRAM_512          11'h200
`define EBAC_XRAM_768          11'h300
`define EBAC_XRAM_1024         11'h400
`define EBAC_XRAM_1792         11'h700

`endif

/* File: logic/ebac_pkg.sv */
package ebac_pkg;

	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ebac_bus_req_t;

	typedef struct packed
	{
		logic       move_data;
		logic       table_read;
		logic       ext_fetch;
	} ebac_access_t;

	typedef struct packed
	{
		logic       strobe;
		logic       strobe_oe;
		logic       pullup_en;
	} ebac_strobe_pin_t;

	typedef enum logic [2:0]
	{
		EBAC_MV_IDLE   = 3'b001,
		EBAC_MV_PULSE  = 3'b010,
		EBAC_MV_DONE   = 3'b100
	} ebac_move_state_t;

endpackage

/* File: logic/ebac_strobe_gen.sv */
`timescale 1ns/1ps
`include "ebac_defines.svh"

module ebac_strobe_gen
(
	// Clock and reset
	input  wire logic       mclk_in,
	input  wire logic       srst_in,
	// Control
	input  wire logic       double_speed_mode_in,
	output logic            strobe_tick_out
);
	import ebac_pkg::*;

	logic [3:0] div_reg;
	logic [3:0] div_limit;

	assign div_limit = double_speed_mode_in ? `EBAC_STROBE_DIV_X2 : `EBAC_STROBE_DIV_STD;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in || div_reg >= div_limit - 4'h1)
			div_reg <= 4'h0;
		else
			div_reg <= div_reg + 4'h1;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			strobe_tick_out <= 1'b0;
		else
			strobe_tick_out <= (div_reg == 4'h0);
	end

endmodule

/* File: logic/ebac_top.sv */
`timescale 1ns/1ps
`include "ebac_defines.svh"

module ebac_top
(
	// Clock and reset
	input  wire logic                       mclk_in,
	input  wire logic                       srst_in,
	// Register port
	input  wire ebac_pkg::ebac_bus_req_t    bus_in,
	output logic [7:0]                      rdata_out,
	// Core status
	input  wire logic                       hardware_security_byte_in,
	input  wire logic                       double_speed_mode_in,
	input  wire ebac_pkg::ebac_access_t     access_in,
	// Strobe pin
	output ebac_pkg::ebac_strobe_pin_t      strobe_pin_out,
	// Data move control
	output logic                            move_strobe_out,
	output logic                            move_busy_out,
	output logic                            external_data_select_out,
	output logic [10:0]                     xram_size_out
);
	import ebac_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Register state

	logic             latch_strobe_suppress_reg;
	logic             external_data_select_reg;
	logic [2:0]       xram_size_select_reg;
	logic             data_move_stretch_select_reg;
	logic [1:0]       reserved_reg;
	logic             strap_loaded_reg;
	logic             strobe_tick;
	logic             ext_access;
	logic             move_start;
	ebac_move_state_t move_state_reg;
	ebac_move_state_t move_state_next;
	logic [4:0]       move_cnt_reg;
	logic [4:0]       move_len;

	function automatic logic [10:0] size_decode(input logic [2:0] sel);
		case (sel)
			3'h0:    size_decode = `EBAC_XRAM_256;
			3'h1:    size_decode = `EBAC_XRAM_512;
			3'h2:    size_decode = `EBAC_XRAM_768;
			3'h3:    size_decode = `EBAC_XRAM_1024;
			3'h4:    size_decode = `EBAC_XRAM_1792;
			default: size_decode = `EBAC_XRAM_768;
		endcase
	endfunction

	wire aux_wr = bus_in.wr && (bus_in.addr == `EBAC_AUX_CTRL_ADDR);

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			latch_strobe_suppress_reg    <= 1'b0;
			xram_size_select_reg         <= `EBAC_XRS_RESET;
			data_move_stretch_select_reg <= 1'b0;
			reserved_reg                 <= 2'h0;
		end
		else if (aux_wr)
		begin
			latch_strobe_suppress_reg    <= bus_in.wdata[`EBAC_SUPPRESS_BIT];
			xram_size_select_reg         <= bus_in.wdata[`EBAC_XRS_MSB:`EBAC_XRS_LSB];
			data_move_stretch_select_reg <= bus_in.wdata[`EBAC_STRETCH_BIT];
			// reserved bits kept, never relied on
			reserved_reg                 <= bus_in.wdata[7:6];
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			strap_loaded_reg         <= 1'b0;
			external_data_select_reg <= 1'b0;
		end
		else if (!strap_loaded_reg)
		begin
			strap_loaded_reg         <= 1'b1;
			external_data_select_reg <= hardware_security_byte_in;
		end
		else if (aux_wr)
			external_data_select_reg <= bus_in.wdata[`EBAC_EXTDATA_BIT];
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			rdata_out <= `EBAC_BYTE_ZERO;
		else if (bus_in.rd && bus_in.addr == `EBAC_AUX_CTRL_ADDR)
			rdata_out <= {reserved_reg, data_move_stretch_select_reg, xram_size_select_reg,
				external_data_select_reg, latch_strobe_suppress_reg};
		else if (bus_in.rd && bus_in.addr == `EBAC_STATUS_ADDR)
			rdata_out <= {6'h00, move_busy_out, strobe_pin_out.strobe_oe};
		else
			rdata_out <= `EBAC_BYTE_ZERO;
	end

	////////////////////////////////////////////////////////////////////////////
	// Address latch strobe

	ebac_strobe_gen u_strobe_gen
	(
		.mclk_in              (mclk_in),
		.srst_in              (srst_in),
		.double_speed_mode_in (double_speed_mode_in),
		.strobe_tick_out      (strobe_tick)
	);

	assign ext_access = access_in.move_data || access_in.table_read || access_in.ext_fetch;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			strobe_pin_out <= '{strobe: 1'b0, strobe_oe: 1'b1, pullup_en: 1'b0};
		else if (!latch_strobe_suppress_reg || ext_access)
			strobe_pin_out <= '{strobe: strobe_tick, strobe_oe: 1'b1, pullup_en: 1'b0};
		else
			strobe_pin_out <= '{strobe: 1'b1, strobe_oe: 1'b0, pullup_en: 1'b1};
	end

	////////////////////////////////////////////////////////////////////////////
	// Expanded RAM routing

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			xram_size_out            <= `EBAC_XRAM_768;
			external_data_select_out <= 1'b0;
		end
		else
		begin
			xram_size_out            <= size_decode(xram_size_select_reg);
			external_data_select_out <= external_data_select_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// External data move pulse

	assign move_len   = data_move_stretch_select_reg ? `EBAC_MOVE_LEN_LONG
		: `EBAC_MOVE_LEN_SHORT;
	assign move_start = access_in.move_data && external_data_select_reg;

	always_comb
	begin
		move_state_next = move_state_reg;
		case (move_state_reg)
			EBAC_MV_IDLE:
				if (move_start)
					move_state_next = EBAC_MV_PULSE;
			EBAC_MV_PULSE:
				if (move_cnt_reg == move_len - 5'h01)
					move_state_next = EBAC_MV_DONE;
			EBAC_MV_DONE:
				if (!access_in.move_data)
					move_state_next = EBAC_MV_IDLE;
			default:
				move_state_next = EBAC_MV_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			move_state_reg <= EBAC_MV_IDLE;
		else
			move_state_reg <= move_state_next;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in || move_state_reg != EBAC_MV_PULSE)
			move_cnt_reg <= 5'h00;
		else
			move_cnt_reg <= move_cnt_reg + 5'h01;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			move_strobe_out <= 1'b0;
			move_busy_out   <= 1'b0;
		end
		else
		begin
			move_strobe_out <= (move_state_next == EBAC_MV_PULSE);
			move_busy_out   <= (move_state_next != EBAC_MV_IDLE);
		end
	end

endmodule

/* File: bench/ebac_top_chk.sv */
`timescale 1ns/1ps
module ebac_top_chk
(
	// Clock and reset
	input wire logic                       mclk_in,
	input wire logic                       srst_in,
	// Register port
	input wire ebac_pkg::ebac_bus_req_t    bus_in,
	input wire logic [7:0]                 rdata_out,
	// Core status
	input wire logic                       hardware_security_byte_in,
	input wire logic                       double_speed_mode_in,
	input wire ebac_pkg::ebac_access_t     access_in,
	// Outputs
	input wire ebac_pkg::ebac_strobe_pin_t strobe_pin_out,
	input wire logic                       move_strobe_out,
	input wire logic                       move_busy_out,
	input wire logic                       external_data_select_out,
	input wire logic [10:0]                xram_size_out
);
	import ebac_pkg::*;
	logic [4:0] len_reg;
	wire so = strobe_pin_out.strobe;
	wire oe = strobe_pin_out.strobe_oe;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	////////////////////////////////////////
	// Move pulse length
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || !move_strobe_out)
			len_reg <= 5'h00;
		else
			len_reg <= len_reg + 5'h01;
	end
	////////////////////////////////////////
	property p_std; disable iff (srst_in || !oe)
		so && oe && !double_speed_mode_in |=> (!so)[*5] ##1 so; endproperty
	a_std: assert property (p_std) else $error("strobe period not 6");
	property p_dbl; disable iff (srst_in || !oe)
		so && oe && double_speed_mode_in |=> (!so)[*2] ##1 so; endproperty
	a_dbl: assert property (p_dbl) else $error("strobe period not 3");
	property p_rel; !oe |-> so && strobe_pin_out.pullup_en; endproperty
	a_rel: assert property (p_rel) else $error("released pin not pulled high");
	property p_acc; (|access_in)[*2] |-> oe; endproperty
	a_acc: assert property (p_acc) else $error("strobe off in access");
	property p_len; $fell(move_strobe_out) |-> len_reg == 5'h06 || len_reg == 5'h1e; endproperty
	a_len: assert property (p_len) else $error("bad move pulse length");
	property p_mvs; $rose(move_strobe_out) |-> external_data_select_out && move_busy_out;
	endproperty
	a_mvs: assert property (p_mvs) else $error("move pulse while internal");
	property p_nomv; (!external_data_select_out)[*3] |-> !move_strobe_out; endproperty
	a_nomv: assert property (p_nomv) else $error("move pulse to internal ram");
	property p_wr; bus_in.wr && bus_in.addr == 8'h8e && !$past(srst_in)
		|-> ##2 external_data_select_out == $past(bus_in.wdata[1], 2); endproperty
	a_wr: assert property (p_wr) else $error("select bit not taken");
	property p_sz; xram_size_out inside {11'h100, 11'h200, 11'h300, 11'h400, 11'h700};
	endproperty
	a_sz: assert property (p_sz) else $error("bad ram size");
	c_mv: cover property ($rose(move_strobe_out));
	c_rel: cover property (!oe);
	c_dbl: cover property (so && double_speed_mode_in);
endmodule

bind ebac_top ebac_top_chk ebac_top_chk_i (.*);

/* File: bench/ebac_ext_mem.sv */
`timescale 1ns/1ps
module ebac_ext_mem
(
	// Clock and control
	input wire logic                       mclk_in,
	input wire logic                       clr_in,
	// Device pins
	input wire ebac_pkg::ebac_strobe_pin_t strobe_pin_in,
	input wire logic                       move_strobe_in,
	// Observation
	output logic [7:0]                     latch_count_out,
	output logic [4:0]                     move_len_out
);
	import ebac_pkg::*;
	logic [4:0] run_reg;
	always_ff @(posedge mclk_in)
	begin
		if (clr_in)
			latch_count_out <= 8'h00;
		else if (strobe_pin_in.strobe && strobe_pin_in.strobe_oe)
			latch_count_out <= latch_count_out + 8'h01;
	end
	always_ff @(posedge mclk_in)
	begin
		run_reg <= move_strobe_in ? run_reg + 5'h01 : 5'h00;
		if (clr_in)
			move_len_out <= 5'h00;
		else if (!move_strobe_in && run_reg != 5'h00)
			move_len_out <= run_reg;
	end
endmodule

/* File: bench/tb_ebac_top.sv */
`timescale 1ns/1ps
module tb_ebac_top;
	import ebac_pkg::*;
	logic mclk_in = 1'b0;
	logic srst_in = 1'b1;
	logic hardware_security_byte = 1'b0, dsm = 1'b0, clr = 1'b0, mst, busy, xsel;
	ebac_bus_req_t bus = '0;
	ebac_access_t acc = '0;
	ebac_strobe_pin_t pin;
	logic [7:0] rdata, lcnt;
	logic [4:0] mlen;
	logic [10:0] xsz;
	int fail_count = 0, n_tests = 0, cyc = 0;
	logic [7:0] wv [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
	logic [10:0] sz [5] = '{11'h100, 11'h200, 11'h300, 11'h400, 11'h700};
	always #4 mclk_in = ~mclk_in;
	ebac_top ebac_top_i (.mclk_in(mclk_in), .srst_in(srst_in), .bus_in(bus),
		.rdata_out(rdata), .hardware_security_byte_in(hardware_security_byte), .double_speed_mode_in(dsm),
		.access_in(acc), .strobe_pin_out(pin), .move_strobe_out(mst),
		.move_busy_out(busy), .external_data_select_out(xsel), .xram_size_out(xsz));
	ebac_ext_mem ebac_ext_mem_i (.mclk_in(mclk_in), .clr_in(clr), .strobe_pin_in(pin),
		.move_strobe_in(mst), .latch_count_out(lcnt), .move_len_out(mlen));
	////////////////////////////////////////
	task automatic chk(input logic [10:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic wr(input logic [7:0] a, d);
		bus <= '{a, {2'b00, d[5:0]}, 1'b1, 1'b0};
		cy(1);
		bus <= '0;
		cy(1);
	endtask
	task automatic rd(input logic [7:0] a, exp);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		cy(1);
		bus <= '0;
		cy(1);
		chk(rdata[5:0], exp[5:0]);
	endtask
	task automatic cnt(input logic [7:0] exp);
		clr <= 1'b1;
		cy(1);
		clr <= 1'b0;
		cy(61);
		chk(lcnt, exp);
	endtask
	task automatic mv(input logic [4:0] exp);
		clr <= 1'b1;
		acc <= 3'b100;
		cy(1);
		clr <= 1'b0;
		cy(40);
		chk(mlen, exp);
		chk(busy, exp != 5'd0);
		acc <= '0;
		cy(3);
		chk(busy, 1'b0);
	endtask
	task automatic rst();
		srst_in <= 1'b1;
		cy(8);
		srst_in <= 1'b0;
		cy(3);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	always @(posedge mclk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			fail_count++;
			summarize();
		end
	end
	initial
	begin
		rst();
		rd(8'h8e, 8'h08);
		rd(8'h8f, 8'h01);
		chk(xsz, 11'h300);
		cnt(8'd10);
		$display("reset test done");
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h8e, wv[i]);
			rd(8'h8e, wv[i]);
			chk(xsz, sz[i]);
		end
		wr(8'h8d, 8'h3f);
		rd(8'h8d, 8'h00);
		rd(8'h8e, 8'h10);
		$display("register test done");
		wr(8'h8e, 8'h09);
		cy(2);
		chk({pin.strobe, pin.strobe_oe, pin.pullup_en}, 3'b101);
		rd(8'h8f, 8'h00);
		cnt(8'd0);
		for (int k = 0; k < 3; k++)
		begin
			acc <= 3'(1 << k);
			cy(2);
			cnt(8'd10);
		end
		acc <= '0;
		$display("suppress test done");
		wr(8'h8e, 8'h0a);
		mv(5'd6);
		wr(8'h8e, 8'h2a);
		mv(5'd30);
		wr(8'h8e, 8'h08);
		mv(5'd0);
		$display("move test done");
		hardware_security_byte <= 1'b1;
		dsm <= 1'b1;
		rst();
		chk(xsel, 1'b1);
		rd(8'h8e, 8'h0a);
		cnt(8'd20);
		$display("strap test done");
		summarize();
	end
endmodule
